// >>> cbu_branch_unit.sv
/*
  cbu_branch_unit.sv: decode and execution of the PC-relative conditional
  branch group: coprocessor-2 false/true, register equality, negative,
  non-negative, non-negative with link and positive.
  assumes: the fetch pipeline presents one 32-bit instruction per accepted
  valid cycle with its own address; operands for both register fields are
  already read; the coprocessor-2 side drives its condition vector; a
  second valid after a branch is that branch's delay slot.
*/
`timescale 1ns/1ns
`include "cbu_cfg.svh"

// Operation
// RL1: target is delay-slot address plus sign-extended offset shifted left one.
// RL2: group opcode with subcode 10100 branches when selected cop2 condition is 0.
// RL3: group opcode with subcode 10101 branches when selected cop2 condition is 1.
// RL4: opcode 100101 compares two registers and branches when they are equal.
// RL5: subcode 00010 branches when source sign bit is zero.
// RL6: subcode 00011 tests non-negative and always writes branch PC plus 8 to r31.
// RL7: subcode 00110 branches when source is non-negative and nonzero.
// RL8: condition judged in branch cycle; redirect only after the delay slot runs.
// RL9: software must put a 32-bit instruction in the linking branch's slot.
// RL10: software must not put branch, jump, return or wait in a delay slot.
// RL11: software must not use r31 as the linking branch's source.
// RL12: cop2 branches can raise coprocessor-unusable and reserved-instruction.
// RL13: equality of register zero with itself is always taken.
// RL14: linking branch on register zero is an always-taken call with link.
// RL15: subcode 00000 branches when source sign bit is one.
// RL16: untaken branch falls through after the slot with only the link effect.
// RL17: the cop2 side holds its condition bits stable during evaluation.
module cbu_branch_unit
  import cbu_pkg::*;
#(
  parameter int XLEN = 32,
  parameter int NUM_COND = 8
)(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  input wire logic [XLEN-1:0] i_pc,
  input wire logic [XLEN-1:0] i_first_source_val,
  input wire logic [XLEN-1:0] i_second_source_val,
  input wire logic [NUM_COND-1:0] i_coproc2_condition,
  input wire logic i_cop2_usable,
  input wire logic i_cop2_present,
  output logic o_redirect,
  output logic [XLEN-1:0] o_next_pc,
  output logic o_link_we,
  output logic [4:0] o_link_reg,
  output logic [XLEN-1:0] o_link_data,
  output logic o_branch_taken,
  output logic o_cop_unusable,
  output logic o_reserved_instr
);

  // ****************************************************************
  // field extraction
  // ****************************************************************
  logic [5:0] op_w;
  logic [4:0] sub_w;
  logic [2:0] condition_select;
  logic [1:0] sel_pad_w;
  logic [15:0] offset_w;
  assign op_w = i_instr[`CBU_OP_HI:`CBU_OP_LO];
  assign sub_w = i_instr[`CBU_F1_HI:`CBU_F1_LO];
  assign condition_select = i_instr[`CBU_SEL_HI:`CBU_SEL_LO];
  assign sel_pad_w = i_instr[`CBU_PAD_HI:`CBU_PAD_LO];
  assign offset_w = i_instr[`CBU_OFF_HI:`CBU_OFF_LO];

  // decode used for both the kind and the exception checks
  function automatic cbu_kind_e decode_kind(input logic [5:0] op, input logic [4:0] sub);
    cbu_kind_e k;
    k = CBU_K_NONE;
    if (op == `CBU_OP_EQUAL)
    begin
      k = CBU_K_EQUAL;
    end
    else if (op == `CBU_OP_IMM_GROUP)
    begin
      unique case (sub)
        `CBU_SUB_COP2_F: k = CBU_K_COP2_F;
        `CBU_SUB_COP2_T: k = CBU_K_COP2_T;
        `CBU_SUB_NONNEG: k = CBU_K_NONNEG;
        `CBU_SUB_NONNEG_LINK: k = CBU_K_NONNEG_LINK;
        `CBU_SUB_POS: k = CBU_K_POS;
        `CBU_SUB_NEG: k = CBU_K_NEG;
        default: k = CBU_K_NONE;
      endcase
    end
    return k;
  endfunction : decode_kind

  // ****************************************************************
  // condition evaluation, judged in the branch cycle
  // ****************************************************************
  cbu_kind_e kind_w;
  logic src_sign_w;
  logic src_zero_w;
  logic sel_cond_w;
  logic is_cop2_w;
  logic cop2_fault_w;
  logic cond_w;
  assign kind_w = i_valid ? decode_kind(op_w, sub_w) : CBU_K_NONE;
  assign src_sign_w = i_first_source_val[XLEN-1];
  assign src_zero_w = (i_first_source_val == '0);
  // out-of-range select reads as false rather than wrapping
  assign sel_cond_w = (int'(condition_select) < NUM_COND) ?
                      i_coproc2_condition[condition_select] : 1'b0;
  assign is_cop2_w = (kind_w == CBU_K_COP2_F) || (kind_w == CBU_K_COP2_T);
  // RL12: cop2 exceptions
  // a nonzero must-be-zero field or a missing unit is reserved; otherwise a
  // disabled unit is unusable; either fault suppresses the branch entirely
  assign cop2_fault_w = is_cop2_w &&
                        (!i_cop2_present || !i_cop2_usable || (sel_pad_w != 2'b00));

  always_comb
  begin
    unique case (kind_w)
      // RL2: false variant
      CBU_K_COP2_F: cond_w = !sel_cond_w;
      // RL3: true variant
      CBU_K_COP2_T: cond_w = sel_cond_w;
      // RL4: equality compare
      // RL13: r0 against r0 compares equal, so always taken
      CBU_K_EQUAL: cond_w = (i_first_source_val == i_second_source_val);
      // RL5: sign bit clear
      // RL14: r0 reads zero, so the linking form always branches
      CBU_K_NONNEG, CBU_K_NONNEG_LINK: cond_w = !src_sign_w;
      // RL7: positive and nonzero
      CBU_K_POS: cond_w = !src_sign_w && !src_zero_w;
      // RL15: sign bit set
      CBU_K_NEG: cond_w = src_sign_w;
      CBU_K_NONE: cond_w = 1'b0;
    endcase
  end

  // RL1: target from the delay-slot address
  logic [XLEN-1:0] off_ext_w;
  logic [XLEN-1:0] slot_pc_w;
  logic [XLEN-1:0] target_w;
  assign off_ext_w = {{(XLEN-17){offset_w[15]}}, offset_w, 1'b0};
  assign slot_pc_w = i_pc + XLEN'(`CBU_SLOT_STEP);
  assign target_w = slot_pc_w + off_ext_w;

  logic is_branch_w;
  logic taken_w;
  assign is_branch_w = (kind_w != CBU_K_NONE) && !cop2_fault_w;
  assign taken_w = is_branch_w && cond_w;

  // ****************************************************************
  // redirect sequencer
  // ****************************************************************
  cbu_state_e state_r;
  cbu_state_e state_nxt;
  logic take_r;
  logic take_nxt;
  logic [XLEN-1:0] tgt_r;
  logic [XLEN-1:0] tgt_nxt;
  logic [XLEN-1:0] fall_r;
  logic [XLEN-1:0] fall_nxt;
  logic slot_done_w;
  // a branch in the slot is not legal, so the slot instruction is not decoded
  // as a new branch; keeping the first outcome is the cheapest defined answer
  assign slot_done_w = (state_r == CBU_S_SLOT) && i_valid;

  always_comb
  begin
    state_nxt = state_r;
    take_nxt = take_r;
    tgt_nxt = tgt_r;
    fall_nxt = fall_r;
    unique case (state_r)
      CBU_S_IDLE:
      begin
        if (is_branch_w)
        begin
          state_nxt = CBU_S_SLOT;
          take_nxt = taken_w;
          tgt_nxt = target_w;
          fall_nxt = i_pc + XLEN'(`CBU_LINK_STEP);
        end
      end
      CBU_S_SLOT:
      begin
        // RL8: wait for the delay slot
        if (i_valid)
        begin
          state_nxt = CBU_S_IDLE;
        end
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_r <= CBU_S_IDLE;
      take_r <= 1'b0;
      tgt_r <= `CBU_PC_RESET;
      fall_r <= `CBU_PC_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      take_r <= take_nxt;
      tgt_r <= tgt_nxt;
      fall_r <= fall_nxt;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  logic link_w;
  assign link_w = (kind_w == CBU_K_NONNEG_LINK) && is_branch_w && (state_r == CBU_S_IDLE);

  // redirect pulse one cycle after the slot is accepted
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_redirect <= 1'b0;
      o_next_pc <= `CBU_PC_RESET;
      o_branch_taken <= 1'b0;
    end
    else
    begin
      // RL16: untaken falls through past the slot
      o_redirect <= slot_done_w;
      o_branch_taken <= slot_done_w && take_r;
      if (slot_done_w)
      begin
        o_next_pc <= take_r ? tgt_r : fall_r;
      end
    end
  end

  // link write and exception pulses, one cycle after the branch is accepted
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_link_we <= 1'b0;
      o_link_reg <= 5'h00;
      o_link_data <= `CBU_PC_RESET;
      o_cop_unusable <= 1'b0;
      o_reserved_instr <= 1'b0;
    end
    else
    begin
      // RL6: link regardless of outcome
      o_link_we <= link_w;
      o_link_reg <= `CBU_LINK_REG;
      if (link_w)
      begin
        o_link_data <= i_pc + XLEN'(`CBU_LINK_STEP);
      end
      // RL12: report the fault
      o_reserved_instr <= (state_r == CBU_S_IDLE) && is_cop2_w &&
                          (!i_cop2_present || (sel_pad_w != 2'b00));
      o_cop_unusable <= (state_r == CBU_S_IDLE) && is_cop2_w && i_cop2_present &&
                        (sel_pad_w == 2'b00) && !i_cop2_usable;
    end
  end

endmodule : cbu_branch_unit

// >>> cbu_cfg.svh
/*
  cbu_cfg.svh: encoding constants, field positions and reset values for the
  conditional branch unit.
  assumes: included by bare name from the package and the design module.
*/
`ifndef CBU_CFG_SVH
`define CBU_CFG_SVH

// ****************************************************************
// opcode encodings
// ****************************************************************
`define CBU_OP_IMM_GROUP 6'h10
`define CBU_OP_EQUAL 6'h25
`define CBU_SUB_NEG 5'h00
`define CBU_SUB_NONNEG 5'h02
`define CBU_SUB_NONNEG_LINK 5'h03
`define CBU_SUB_POS 5'h06
`define CBU_SUB_COP2_F 5'h14
`define CBU_SUB_COP2_T 5'h15

// ****************************************************************
// field positions
// ****************************************************************
`define CBU_OP_HI 31
`define CBU_OP_LO 26
`define CBU_F1_HI 25
`define CBU_F1_LO 21
`define CBU_F2_HI 20
`define CBU_F2_LO 16
`define CBU_SEL_HI 20
`define CBU_SEL_LO 18
`define CBU_PAD_HI 17
`define CBU_PAD_LO 16
`define CBU_OFF_HI 15
`define CBU_OFF_LO 0

// ****************************************************************
// constants
// ****************************************************************
`define CBU_LINK_REG 5'h1f
`define CBU_SLOT_STEP 4
`define CBU_LINK_STEP 8
`define CBU_PC_RESET 32'h0000_0000

`endif

// >>> cbu_pkg.sv
/*
  cbu_pkg.sv: types shared by the conditional branch unit.
  assumes: cbu_cfg.svh is on the include path.
*/
package cbu_pkg;
  `include "cbu_cfg.svh"

  // branch kind decoded from the instruction word
  typedef enum logic [2:0] {
    CBU_K_NONE = 3'b000,
    CBU_K_COP2_F = 3'b001,
    CBU_K_COP2_T = 3'b010,
    CBU_K_EQUAL = 3'b011,
    CBU_K_NONNEG = 3'b100,
    CBU_K_NONNEG_LINK = 3'b101,
    CBU_K_POS = 3'b110,
    CBU_K_NEG = 3'b111
  } cbu_kind_e;

  // redirect sequencer
  typedef enum logic [0:0] {
    CBU_S_IDLE = 1'b0,
    CBU_S_SLOT = 1'b1
  } cbu_state_e;
endpackage : cbu_pkg

// >>> cbu_branch_unit_monitor.sv
/* cbu_branch_unit_monitor.sv: port-level checker for the branch unit.
   assumes: bound into cbu_branch_unit; one clock, async low reset. */
`timescale 1ns/1ns
module cbu_branch_unit_monitor #(
  parameter int XLEN = 32
)(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  input wire logic [XLEN-1:0] i_pc,
  input wire logic i_cop2_usable,
  input wire logic i_cop2_present,
  input wire logic o_redirect,
  input wire logic [XLEN-1:0] o_next_pc,
  input wire logic o_link_we,
  input wire logic [4:0] o_link_reg,
  input wire logic [XLEN-1:0] o_link_data,
  input wire logic o_branch_taken,
  input wire logic o_cop_unusable,
  input wire logic o_reserved_instr
);
  // ****
  // shadow decode
  // ****
  // tracks the branch waiting for its slot, so timing can be judged from ports alone
  logic pend_r;
  logic [XLEN-1:0] tgt_r;
  logic [XLEN-1:0] seq_r;
  wire grp_w = i_instr[31:26] == 6'h10;
  wire [4:0] sub_w = i_instr[25:21];
  wire c2_w = grp_w && sub_w[4:1] == 4'ha;
  wire link_w = grp_w && sub_w == 5'h03;
  wire flt_w = c2_w && !(i_cop2_present && i_cop2_usable && i_instr[17:16] == 2'h0);
  wire br_w = i_instr[31:26] == 6'h25 || c2_w || link_w
    || grp_w && (sub_w == 5'h00 || sub_w == 5'h02 || sub_w == 5'h06);
  wire issue_w = i_valid && !pend_r && br_w && !flt_w;
  // pending flag: any accepted word while pending is the slot
  always_ff @(posedge i_sys_clk or negedge i_rstn)
    if (!i_rstn) pend_r <= 1'b0;
    else if (i_valid) pend_r <= issue_w;
  // expected targets captured at the branch edge
  always_ff @(posedge i_sys_clk)
    if (issue_w)
    begin
      tgt_r <= i_pc + 4 + {{(XLEN-17){i_instr[15]}}, i_instr[15:0], 1'b0};
      seq_r <= i_pc + 8;
    end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_link_issue;
    issue_w && link_w;
  endsequence
  sequence s_slot;
    i_valid && pend_r;
  endsequence
  AST_LINK_ISSUE: assert property (s_link_issue |=> o_link_we && o_link_data == $past(i_pc) + 8)
    else $error("link write missing or wrong");
  AST_LINK_ONLY: assert property (o_link_we |-> $past(issue_w && link_w))
    else $error("link write without linking branch");
  AST_LINK_REG: assert property ($past(i_rstn) |-> o_link_reg == 5'h1f)
    else $error("link register index wrong");
  AST_SLOT_REDIRECT: assert property (s_slot |=> o_redirect)
    else $error("no redirect after delay slot");
  AST_NO_EARLY: assert property (o_redirect |-> $past(i_valid && pend_r))
    else $error("redirect before delay slot");
  AST_TAKEN_PC: assert property (o_redirect && o_branch_taken |-> o_next_pc == tgt_r)
    else $error("taken target wrong");
  AST_FALL_PC: assert property (o_redirect && !o_branch_taken |-> o_next_pc == seq_r)
    else $error("fall-through address wrong");
  AST_TAKEN_WITH_REDIRECT: assert property (o_branch_taken |-> o_redirect)
    else $error("taken flag without redirect");
  AST_COP_FAULT: assert property (o_cop_unusable || o_reserved_instr
    |-> $past(i_valid && !pend_r && flt_w) && !o_link_we)
    else $error("exception pulse without faulting cop2 branch");
endmodule : cbu_branch_unit_monitor

bind cbu_branch_unit cbu_branch_unit_monitor #(.XLEN(XLEN)) u_mon (.*);

// >>> cbu_cop2_model.sv
/* cbu_cop2_model.sv: coprocessor-2 condition source beside the branch unit.
   assumes: the bench loads new bits only while no branch is in flight. */
`timescale 1ns/1ns
module cbu_cop2_model #(
  parameter int NUM_COND = 8
)(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_load,
  input wire logic [NUM_COND-1:0] i_cond,
  output logic [NUM_COND-1:0] o_coproc2_condition
);
  // ****
  // condition bits
  // ****
  // bits held stable
  // registered, so bits move only on a load edge and never mid-evaluation
  always_ff @(posedge i_sys_clk or negedge i_rstn)
    if (!i_rstn) o_coproc2_condition <= {NUM_COND{1'b0}};
    else if (i_load) o_coproc2_condition <= i_cond;
endmodule : cbu_cop2_model

// >>> cbu_branch_unit_tb.sv
/* cbu_branch_unit_tb.sv: self-checking bench for the conditional branch unit.
   assumes: package, monitor and cop2 model are compiled first. */
`timescale 1ns/1ns
module cbu_branch_unit_tb;
  logic i_sys_clk, i_rstn, i_valid, i_cop2_usable, i_cop2_present, ld;
  logic [31:0] i_instr, i_pc, i_first_source_val, i_second_source_val;
  logic [7:0] ld_val, i_coproc2_condition;
  logic o_redirect, o_link_we, o_branch_taken, o_cop_unusable, o_reserved_instr;
  logic [31:0] o_next_pc, o_link_data;
  logic [4:0] o_link_reg;
  int n_mismatch = 0;
  int n_checks = 0;
  cbu_branch_unit u_dut (.*);
  cbu_cop2_model u_cop2 (.i_sys_clk, .i_rstn, .i_load(ld), .i_cond(ld_val),
    .o_coproc2_condition(i_coproc2_condition));
  // ****
  // clock and shared tasks
  // ****
  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // inputs always move 5 ns after the edge, clear of sampling
  task automatic step;
    @(posedge i_sys_clk);
    #5;
  endtask : step
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  function automatic logic [31:0] enc(input logic [5:0] op, input logic [4:0] f1, f2,
    input logic [15:0] off);
    return {op, f1, f2, off};
  endfunction : enc
  // branch, slot after gap idle cycles, then redirect
  task automatic run_br(input logic [31:0] ins, a, b, input int gap, input logic tk);
    logic [31:0] pc;
    logic lk;
    pc = 32'h0040_0000 + n_checks * 8;
    lk = ins[31:21] == 11'h203;
    i_valid = 1'b1;
    i_instr = ins;
    i_pc = pc;
    i_first_source_val = a;
    i_second_source_val = b;
    step;
    i_valid = gap == 0;
    i_pc = pc + 32'h0000_0004;
    i_instr = 32'h0000_0000; // a 32-bit non-branch word fills the delay slot
    chk({o_cop_unusable, o_reserved_instr, o_link_we}, {2'b00, lk});
    if (lk) chk(o_link_data, pc + 32'h0000_0008);
    for (int k = 1; k <= gap; k++)
    begin
      step;
      chk(o_redirect, 1'b0);
      i_valid = k == gap;
    end
    step;
    i_valid = 1'b0;
    chk({o_redirect, o_branch_taken}, {1'b1, tk});
    chk(o_next_pc, tk ? pc + 32'h0000_0004 + {{15{ins[15]}}, ins[15:0], 1'b0}
      : pc + 32'h0000_0008);
    step;
    chk(o_redirect, 1'b0);
  endtask : run_br
  task automatic run_flt(input logic [31:0] ins, input logic use_ok, here, cu, ri);
    i_cop2_usable = use_ok;
    i_cop2_present = here;
    i_valid = 1'b1;
    i_instr = ins;
    step;
    i_valid = 1'b0;
    // restored here so the next call never drives them twice in one time step
    i_cop2_usable = 1'b1;
    i_cop2_present = 1'b1;
    chk({o_cop_unusable, o_reserved_instr, o_link_we}, {cu, ri, 1'b0});
    step;
    chk(o_redirect, 1'b0);
  endtask : run_flt
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    repeat (10) step;
    chk({o_redirect, o_link_we, o_link_reg}, 32'h0000_0000);
    i_rstn = 1'b1;
    step;
    chk(o_link_reg, 5'h1f);
  endtask : t_reset
  // sign tests on negative, zero and positive
  task automatic t_sign;
    logic [31:0] v [3] = '{32'h8000_0000, 32'h0000_0000, 32'h0000_0001};
    logic [4:0] s [4] = '{5'h00, 5'h02, 5'h06, 5'h03};
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 3; j++)
        run_br(enc(6'h10, s[i], 5'h05, j[0] ? 16'h8002 : 16'h1234), v[j], 32'h0, j,
          i == 0 ? v[j][31] : !v[j][31] && (i != 2 || v[j] != 0));
    run_br(enc(6'h10, 5'h03, 5'h00, 16'h7fff), 32'h0, 32'h0, 0, 1'b1);
  endtask : t_sign
  // equality, including register zero with itself
  task automatic t_equal;
    run_br(enc(6'h25, 5'h07, 5'h09, 16'hfffe), 32'h1234_5678, 32'h1234_5678, 0, 1'b1);
    run_br(enc(6'h25, 5'h07, 5'h09, 16'h0010), 32'h1234_5678, 32'h9234_5678, 1, 1'b0);
    run_br(enc(6'h25, 5'h00, 5'h00, 16'h0040), 32'h0, 32'h0, 0, 1'b1);
  endtask : t_equal
  // every condition select, false and true
  task automatic t_cop2;
    ld = 1'b1;
    ld_val = 8'ha5;
    step;
    ld = 1'b0;
    for (int c = 0; c < 16; c++)
      run_br(enc(6'h10, {4'ha, c[3]}, {c[2:0], 2'b00}, 16'hff00), 32'h0, 32'h0, 0,
        ld_val[c[2:0]] == c[3]);
  endtask : t_cop2
  // unusable, absent, nonzero reserved bits, then a clean branch
  task automatic t_fault;
    run_flt(enc(6'h10, 5'h14, 5'h00, 16'h0004), 1'b0, 1'b1, 1'b1, 1'b0);
    run_flt(enc(6'h10, 5'h15, 5'h00, 16'h0004), 1'b1, 1'b0, 1'b0, 1'b1);
    run_flt(enc(6'h10, 5'h14, 5'h01, 16'h0004), 1'b1, 1'b1, 1'b0, 1'b1);
    run_flt(enc(6'h10, 5'h15, 5'h00, 16'h0004), 1'b0, 1'b0, 1'b0, 1'b1);
    run_flt(enc(6'h00, 5'h14, 5'h00, 16'h0004), 1'b1, 1'b1, 1'b0, 1'b0);
    run_br(enc(6'h10, 5'h02, 5'h01, 16'h0008), 32'h0, 32'h0, 0, 1'b1);
  endtask : t_fault
  initial
  begin
    {i_valid, i_cop2_usable, i_cop2_present, ld} = 4'h6;
    i_rstn = 1'b0;
    i_instr = 32'h0000_0000;
    i_pc = 32'h0000_0000;
    i_first_source_val = 32'h0000_0000;
    i_second_source_val = 32'h0000_0000;
    ld_val = 8'h00;
    #5;
    t_reset;
    t_sign;
    t_equal;
    t_cop2;
    t_fault;
    report_and_stop;
  end
  // watchdog: the run needs some 134 cycles, so 8000 means a hang
  initial
  begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end
endmodule : cbu_branch_unit_tb
